// ---- shared/pqf_pkg.sv ----
`default_nettype none
package pqf_pkg;
	// ==================================================
	// Register map (word offsets, byte addresses)
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_THRESH = 8'h0C;
	localparam logic [7:0] ADDR_PCFG = 8'h10;
	localparam logic [7:0] ADDR_PVAL_LO = 8'h14;
	localparam logic [7:0] ADDR_PVAL_HI = 8'h18;
	localparam logic [7:0] ADDR_PINMAP = 8'h1C;
	// ==================================================
	// Status bits
	localparam int ST_DRAINED = 0;
	localparam int ST_FULL = 1;
	localparam int ST_LEVEL = 2;
	localparam int ST_OVERFLOW = 3;
	localparam int ST_TXDONE = 4;
	localparam int ST_MATCH = 5;
	// Control bits
	localparam int CT_MODE_LO = 0;
	localparam int CT_PACKET = 3;
	localparam int CT_BITSYNC = 4;
	localparam int CT_TXDONE_CLR = 5;
	// Pattern config bits
	localparam int PC_ENABLE = 3;
	// ==================================================
	// Sizes and reset values
	localparam int DEPTH = 64;
	localparam int PTR_W = 6;
	localparam int CNT_W = 7;
	localparam logic [5:0] THRESH_RESET = 6'h0F;
	localparam logic [2:0] PLEN_RESET = 3'h3;
	localparam logic [63:0] PVAL_RESET = 64'h0101010101010101;
	localparam logic [11:0] PINMAP_RESET = 12'h000;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

	typedef enum logic [2:0] {
		PQF_SLEEP = 3'b000,
		PQF_STDBY = 3'b001,
		PQF_FS = 3'b010,
		PQF_TX = 3'b011,
		PQF_RX = 3'b100
	} pqf_mode_t;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic drained;
		logic full;
	} pqf_occ_t;
endpackage : pqf_pkg
`default_nettype wire

// ---- design/pqf_core.sv ----
// The placing of the registers and the Wishbone slave port were left to the implementer.
`default_nettype none
// How it works
// - Drained flag high exactly when the queue holds no byte.
// - During reads, drained sets as soon as the last byte leaves; select level does not delay it.
// - Full flag high when all 64 locations hold data.
// - Write into full queue sets overflow and drops the byte.
// - Writing one to overflow clears it and flushes the queue.
// - Frame-done rises after the shifter sends its final bit.
// - Level flag recomputed only on queue read, write or flush.
// - After full, level is frozen until queue fully empties.
// - Keep queue entering transmit from idle; flush on other listed transitions.
// - Keep queue between standby and sleep and from receive to idle.
// - Received bits shift into a compare register; match sets flag.
// - First bit meets first byte's MSB; last meets last byte's LSB.
// - Match flag cleared on leaving receive, or on queue emptying in a cycle without a bit-clock rise.
// - Pattern length one to eight bytes, used for receive only.
// - Pattern value is 64 bits, used for receive only.
// - Six pins, two-bit code each, mode dependent.
// - Continuous mode code 00 and 11 pin functions.
// - Packet mode pin 0, 1 and 3 functions.
// - Queue is 64 bytes deep, shared by both directions.
// - Transmit shifts bytes out MSB first at bit rate.
module pqf_core
	import pqf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial link pins
	input wire logic spi_select_n,
	input wire logic bit_clk_in,
	input wire logic rx_bit_in,
	output logic tx_bit_out,
	// Chip status inputs, same clock
	input wire logic rx_payload_done,
	input wire logic checksum_good,
	input wire logic rx_timeout,
	input wire logic mode_settled,
	input wire logic ref_clock_out,
	// IO lines
	output logic io_line_0,
	output logic io_line_1,
	output logic io_line_2,
	output logic io_line_3,
	output logic io_line_4,
	output logic io_line_5
);
	// ==================================================
	// Storage and registers
	logic [7:0] mem [0:DEPTH-1];
	logic [PTR_W-1:0] wr_ptr, rd_ptr;
	logic [CNT_W-1:0] count;
	logic queue_drained, queue_full_flag, queue_overflow_flag, frame_tx_done;
	logic queue_level_irq, level_frozen, pattern_match_flag;
	logic [2:0] mode, prev_mode;
	logic packet_mode, bitsync_en, pattern_detect_enable;
	logic [5:0] queue_level_threshold;
	logic [2:0] pattern_length_field;
	logic [63:0] pattern_value;
	logic [11:0] pin_map;
	logic [63:0] cmp_reg;
	logic [7:0] bit_shifter;
	logic [3:0] bits_left;
	logic shifter_busy;
	// Synchronisers for pins
	logic [1:0] ss_sync, bc_sync, rx_sync;
	logic ss_d, bc_d;
	logic [7:0] rd_data_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ss_sync <= 2'h3;
			bc_sync <= 2'h0;
			rx_sync <= 2'h0;
			ss_d <= 1'b1;
			bc_d <= 1'b0;
		end else begin
			ss_sync <= {ss_sync[0], spi_select_n};
			bc_sync <= {bc_sync[0], bit_clk_in};
			rx_sync <= {rx_sync[0], rx_bit_in};
			ss_d <= ss_sync[1];
			bc_d <= bc_sync[1];
		end
	end

	logic ss_fall, bc_rise;
	assign ss_fall = ss_d & ~ss_sync[1];
	assign bc_rise = ~bc_d & bc_sync[1];

	// ==================================================
	// Bus decode
	logic req, wr_req, rd_data_req, wr_data_req, ovf_clr;
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_req = req & wb_we_i;
	assign rd_data_req = req & ~wb_we_i & (wb_adr_i == ADDR_DATA);
	assign wr_data_req = wr_req & (wb_adr_i == ADDR_DATA) & wb_sel_i[0];
	assign ovf_clr = wr_req & (wb_adr_i == ADDR_STATUS) & wb_sel_i[0]
		& wb_dat_i[ST_OVERFLOW];

	// ==================================================
	// Mode transitions and flush
	logic flush;
	always_comb begin
		flush = ovf_clr;
		if (mode != prev_mode) begin
			if (prev_mode == PQF_TX)
				flush = 1'b1;
			else if (mode == PQF_RX)
				flush = 1'b1;
			else if (prev_mode == PQF_RX && mode == PQF_TX)
				flush = 1'b1;
		end
		// Other transitions keep contents
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			prev_mode <= PQF_SLEEP;
		else
			prev_mode <= mode;
	end

	// ==================================================
	// Queue writes: host in tx/standby/sleep, receiver in rx
	logic rx_byte_ready;
	logic [7:0] rx_byte;
	logic push_req, push, pop;
	logic [7:0] push_data;
	logic tx_load;
	always_comb begin
		push_req = 1'b0;
		push_data = wb_dat_i[7:0];
		if (mode == PQF_RX) begin
			push_req = rx_byte_ready;
			push_data = rx_byte;
		end else if (mode != PQF_FS) begin
			push_req = wr_data_req;
		end
	end
	assign push = push_req & ~queue_full_flag & ~flush;
	assign pop = (rd_data_req | tx_load) & (count != '0) & ~flush;

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= push_data;
	end

	always_ff @(posedge clk) begin
		if (!resetn || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + CNT_W'(push) - CNT_W'(pop);
		end
	end

	logic [CNT_W-1:0] count_next;
	assign count_next = flush ? '0 : count + CNT_W'(push) - CNT_W'(pop);
	assign queue_full_flag = (count == CNT_W'(DEPTH));

	// Drained: sets at once when the queue empties, whether reading or not
	always_ff @(posedge clk) begin
		if (!resetn)
			queue_drained <= 1'b1;
		else if (count_next == '0)
			queue_drained <= 1'b1;
		else if (push || ss_fall || ss_sync[1])
			queue_drained <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			queue_overflow_flag <= 1'b0;
		else if (push_req && queue_full_flag && !flush)
			queue_overflow_flag <= 1'b1;
		else if (ovf_clr)
			queue_overflow_flag <= 1'b0;
	end

	// Level flag: only on access or flush, frozen after full until empty
	always_ff @(posedge clk) begin
		if (!resetn) begin
			queue_level_irq <= 1'b0;
			level_frozen <= 1'b0;
		end else begin
			if (count_next == '0)
				level_frozen <= 1'b0;
			else if (count_next == CNT_W'(DEPTH))
				level_frozen <= 1'b1;
			if ((push || pop || flush) && !(level_frozen && count_next != '0))
				queue_level_irq <= (count_next > {1'b0, queue_level_threshold});
		end
	end

	// ==================================================
	// Transmit shifter
	assign tx_load = (mode == PQF_TX) && !shifter_busy && bc_rise && count != '0;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bit_shifter <= 8'h00;
			bits_left <= 4'h0;
			shifter_busy <= 1'b0;
			tx_bit_out <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			if (pop)
				rd_data_q <= mem[rd_ptr];
			if (mode != PQF_TX) begin
				shifter_busy <= 1'b0;
				bits_left <= 4'h0;
			end else if (tx_load) begin
				bit_shifter <= {mem[rd_ptr][6:0], 1'b0};
				tx_bit_out <= mem[rd_ptr][7];
				bits_left <= 4'h7;
				shifter_busy <= 1'b1;
			end else if (shifter_busy && bc_rise) begin
				if (bits_left == 4'h0) begin
					shifter_busy <= 1'b0;
				end else begin
					tx_bit_out <= bit_shifter[7];
					bit_shifter <= {bit_shifter[6:0], 1'b0};
					bits_left <= bits_left - 4'h1;
				end
			end
		end
	end

	logic tx_clr;
	assign tx_clr = wr_req & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0] & wb_dat_i[CT_TXDONE_CLR];
	always_ff @(posedge clk) begin
		if (!resetn)
			frame_tx_done <= 1'b0;
		else if (shifter_busy && bc_rise && bits_left == 4'h0 && count == '0)
			frame_tx_done <= 1'b1;
		else if (tx_clr || mode != PQF_TX)
			frame_tx_done <= 1'b0;
	end

	// ==================================================
	// Receive: pattern search then bytes into queue
	logic search_on;
	logic [6:0] plen_bits;
	logic [63:0] plen_mask;
	logic [2:0] rx_bit_cnt;
	assign search_on = pattern_detect_enable && (packet_mode || bitsync_en);
	assign plen_bits = {pattern_length_field + 4'h1, 3'b000};
	// Pattern aligned so first byte sits at the top of the used window
	assign plen_mask = (plen_bits == 7'd64) ? 64'hFFFFFFFFFFFFFFFF
		: ((64'h1 << plen_bits) - 64'h1);
	logic [63:0] pat_aligned;
	assign pat_aligned = pattern_value >> (7'd64 - plen_bits);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cmp_reg <= 64'h0;
			pattern_match_flag <= 1'b0;
			rx_bit_cnt <= 3'h0;
			rx_byte <= 8'h00;
			rx_byte_ready <= 1'b0;
		end else begin
			rx_byte_ready <= 1'b0;
			if (mode != PQF_RX || !search_on) begin
				pattern_match_flag <= 1'b0;
				rx_bit_cnt <= 3'h0;
			end else if (bc_rise) begin
				cmp_reg <= {cmp_reg[62:0], rx_sync[1]};
				if (!pattern_match_flag) begin
					if ((({cmp_reg[62:0], rx_sync[1]} ^ pat_aligned) & plen_mask) == 64'h0)
						pattern_match_flag <= 1'b1;
				end else if (packet_mode) begin
					rx_byte <= {rx_byte[6:0], rx_sync[1]};
					rx_bit_cnt <= rx_bit_cnt + 3'h1;
					if (rx_bit_cnt == 3'h7)
						rx_byte_ready <= 1'b1;
				end
			end else if (count != '0 && count_next == '0) begin
				pattern_match_flag <= 1'b0;
			end
		end
	end

	// ==================================================
	// Register writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode <= PQF_SLEEP;
			packet_mode <= 1'b1;
			bitsync_en <= 1'b0;
			queue_level_threshold <= THRESH_RESET;
			pattern_detect_enable <= 1'b1;
			pattern_length_field <= PLEN_RESET;
			pattern_value <= PVAL_RESET;
			pin_map <= PINMAP_RESET;
		end else if (wr_req && wb_sel_i[0]) begin
			if (wb_adr_i == ADDR_CTRL) begin
				mode <= wb_dat_i[CT_MODE_LO +: 3];
				packet_mode <= wb_dat_i[CT_PACKET];
				bitsync_en <= wb_dat_i[CT_BITSYNC];
			end else if (wb_adr_i == ADDR_THRESH)
				queue_level_threshold <= wb_dat_i[5:0];
			else if (wb_adr_i == ADDR_PCFG) begin
				pattern_length_field <= wb_dat_i[2:0];
				pattern_detect_enable <= wb_dat_i[PC_ENABLE];
			end else if (wb_adr_i == ADDR_PVAL_LO)
				pattern_value[31:0] <= wb_dat_i;
			else if (wb_adr_i == ADDR_PVAL_HI)
				pattern_value[63:32] <= wb_dat_i;
			else if (wb_adr_i == ADDR_PINMAP)
				pin_map <= wb_dat_i[11:0];
		end
	end

	// ==================================================
	// Bus answer: one cycle after request, data reads included
	logic rd_pending;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			rd_pending <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			rd_pending <= rd_data_req;
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				if (wb_adr_i == ADDR_STATUS)
					wb_dat_o <= {26'h0, pattern_match_flag, frame_tx_done, queue_overflow_flag,
						queue_level_irq, queue_full_flag, queue_drained};
				else if (wb_adr_i == ADDR_CTRL)
					wb_dat_o <= {27'h0, bitsync_en, packet_mode, mode};
				else if (wb_adr_i == ADDR_THRESH)
					wb_dat_o <= {26'h0, queue_level_threshold};
				else if (wb_adr_i == ADDR_PCFG)
					wb_dat_o <= {28'h0, pattern_detect_enable, pattern_length_field};
				else if (wb_adr_i == ADDR_PVAL_LO)
					wb_dat_o <= pattern_value[31:0];
				else if (wb_adr_i == ADDR_PVAL_HI)
					wb_dat_o <= pattern_value[63:32];
				else if (wb_adr_i == ADDR_PINMAP)
					wb_dat_o <= {20'h0, pin_map};
				else if (wb_adr_i == ADDR_DATA)
					wb_dat_o <= (count != '0) ? {24'h0, mem[rd_ptr]} : 32'h0;
				else
					wb_dat_o <= UNMAPPED_READ;
			end
		end
	end

	// ==================================================
	// Pin mapping
	function automatic logic [1:0] code_of(input logic [11:0] m, input int pin);
		code_of = m[pin*2 +: 2];
	endfunction

	logic [5:0] next_io;
	logic in_rx, in_tx;
	assign in_rx = (mode == PQF_RX);
	assign in_tx = (mode == PQF_TX);
	always_comb begin
		next_io = 6'h0;
		if (!packet_mode) begin
			if (code_of(pin_map, 0) == 2'b00)
				next_io[0] = in_rx ? pattern_match_flag : (in_tx & ~shifter_busy);
			if (code_of(pin_map, 1) == 2'b00)
				next_io[1] = (in_rx | in_tx) & bc_sync[1];
			next_io[2] = in_rx ? rx_sync[1] : tx_bit_out;
			if (code_of(pin_map, 3) == 2'b00)
				next_io[3] = in_rx & rx_timeout;
			if (code_of(pin_map, 4) == 2'b11)
				next_io[4] = mode_settled;
			if (code_of(pin_map, 5) == 2'b00)
				next_io[5] = ref_clock_out;
			else if (code_of(pin_map, 5) == 2'b11)
				next_io[5] = mode_settled;
		end else begin
			if (code_of(pin_map, 0) == 2'b00)
				next_io[0] = in_rx ? rx_payload_done : (in_tx & frame_tx_done);
			else if (code_of(pin_map, 0) == 2'b01)
				next_io[0] = in_rx & checksum_good;
			if (code_of(pin_map, 1) == 2'b00)
				next_io[1] = queue_level_irq;
			else if (code_of(pin_map, 1) == 2'b01)
				next_io[1] = queue_drained;
			else if (code_of(pin_map, 1) == 2'b10)
				next_io[1] = queue_full_flag;
			next_io[2] = queue_full_flag;
			if (code_of(pin_map, 3) != 2'b01)
				next_io[3] = queue_drained;
			if (code_of(pin_map, 5) == 2'b00)
				next_io[5] = ref_clock_out;
			else if (code_of(pin_map, 5) == 2'b11)
				next_io[5] = mode_settled;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			{io_line_5, io_line_4, io_line_3, io_line_2, io_line_1, io_line_0} <= 6'h0;
		else
			{io_line_5, io_line_4, io_line_3, io_line_2, io_line_1, io_line_0} <= next_io;
	end
endmodule : pqf_core
`default_nettype wire

// ---- testbench/pqf_properties.sv ----
`default_nettype none
module pqf_properties
	import pqf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Link
	input wire logic bit_clk_in,
	input wire logic tx_bit_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ==========================
	// Helpers
	logic rd;
	logic [3:0] quiet;
	assign rd = wb_ack_o && !wb_we_i;
	// Serial output may only move shortly after a link edge or a bus write
	always_ff @(posedge clk) begin
		if (!resetn || $rose(bit_clk_in) || (wb_ack_o && wb_we_i))
			quiet <= 4'h0;
		else if (quiet != 4'hF)
			quiet <= quiet + 4'h1;
	end
	// ==========================
	// Properties
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_stb_i) && wb_cyc_i;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_unmapped;
		rd && wb_adr_i > ADDR_PINMAP |-> wb_dat_o == UNMAPPED_READ;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
	property p_full_drained;
		rd && wb_adr_i == ADDR_STATUS |-> !(wb_dat_o[ST_DRAINED] && wb_dat_o[ST_FULL]);
	endproperty
	a_full_drained: assert property (p_full_drained) else $error("full and drained");
	property p_stat_resv;
		rd && wb_adr_i == ADDR_STATUS |-> wb_dat_o[31:6] == 26'h0;
	endproperty
	a_stat_resv: assert property (p_stat_resv) else $error("status spare bits set");
	property p_tx_cause;
		$changed(tx_bit_out) |-> quiet < 4'h8;
	endproperty
	a_tx_cause: assert property (p_tx_cause) else $error("tx bit moved alone");
	property p_rst_quiet;
		@(posedge clk) disable iff (1'b0) !resetn |=> !wb_ack_o && !tx_bit_out;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live in reset");
endmodule // pqf_properties
bind pqf_core pqf_properties u_props (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .bit_clk_in(bit_clk_in), .tx_bit_out(tx_bit_out));
`default_nettype wire

// ---- testbench/pqf_link_partner.sv ----
`default_nettype none
module pqf_link_partner (
	// Link pins
	output logic bclk,
	output logic rx_bit,
	input wire logic tx_bit
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] cap = 64'h0;
	initial begin
		bclk = 1'b0;
		rx_bit = 1'b0;
	end
	// Sample late in the bit so the synchronised tx output has settled
	always @(posedge bclk) begin
		#75;
		cap <= {cap[62:0], tx_bit};
	end
	// Clock runs only within a frame; first bit sent is the oldest
	task automatic send(input logic [63:0] bits, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			rx_bit <= bits[i];
			#40 bclk <= 1'b1;
			#40 bclk <= 1'b0;
		end
		#40;
		rx_bit <= ~rx_bit;
	endtask
endmodule // pqf_link_partner
`default_nettype wire

// ---- testbench/pqf_core_tb.sv ----
`default_nettype none
module pqf_core_tb
	import pqf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, wen = 1'b0, ack, txb, bclk, rxb;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic ok = 1'b0, to = 1'b0, ms = 1'b0, pd = 1'b0, ssn = 1'b1;
	logic [5:0] io;
	int mismatches = 0, n_tests = 0;
	pqf_core dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.spi_select_n(ssn), .bit_clk_in(bclk), .rx_bit_in(rxb), .tx_bit_out(txb),
		.rx_payload_done(pd), .checksum_good(ok), .rx_timeout(to), .mode_settled(ms),
		.ref_clock_out(1'b0), .io_line_0(io[0]), .io_line_1(io[1]), .io_line_2(io[2]),
		.io_line_3(io[3]), .io_line_4(io[4]), .io_line_5(io[5]));
	pqf_link_partner u_link (.bclk(bclk), .rx_bit(rxb), .tx_bit(txb));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================
	// Shared tasks
	task automatic report_and_stop;
		$display("tests=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ck(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		wen <= we;
		adr <= a;
		wdat <= d;
		for (int n = 0; n < 20; n++) begin
			@(posedge clk);
			if (ack === 1'b1) begin
				rd = rdat;
				break;
			end
			if (n == 19) begin
				mismatches++;
				report_and_stop();
			end
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic st(input int b, input logic e);
		wb(1'b0, ADDR_STATUS, 32'h0);
		ck(rd[b], e);
	endtask
	task automatic md(input pqf_mode_t m);
		wr(ADDR_CTRL, 32'h8 | 32'(m));
	endtask
	task automatic pin(input int p, input logic e);
		repeat (3) @(posedge clk);
		ck(io[p], e);
	endtask
	// ==========================
	// Scenarios
	task automatic s_fill;
		st(ST_DRAINED, 1'b1);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, UNMAPPED_READ);
		md(PQF_STDBY);
		for (int i = 0; i < 21; i++) begin
			wr(ADDR_DATA, 32'(i));
			st(ST_LEVEL, i >= int'(THRESH_RESET));
		end
		wr(ADDR_THRESH, 32'h3F);
		st(ST_LEVEL, 1'b1);
		wr(ADDR_DATA, 32'h15);
		st(ST_LEVEL, 1'b0);
		for (int i = 22; i < 63; i++)
			wr(ADDR_DATA, 32'(i));
		st(ST_FULL, 1'b0);
		wr(ADDR_DATA, 32'h3F);
		st(ST_FULL, 1'b1);
		wr(ADDR_DATA, 32'hAA);
		st(ST_OVERFLOW, 1'b1);
		wb(1'b0, ADDR_DATA, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h0);
		st(ST_DRAINED, 1'b0);
		wr(ADDR_STATUS, 32'h8);
		st(ST_OVERFLOW, 1'b0);
		st(ST_DRAINED, 1'b1);
	endtask
	task automatic s_modes;
		wr(ADDR_DATA, 32'h11);
		md(PQF_SLEEP);
		md(PQF_STDBY);
		st(ST_DRAINED, 1'b0);
		md(PQF_RX);
		st(ST_DRAINED, 1'b1);
		md(PQF_STDBY);
		wr(ADDR_DATA, 32'h22);
		md(PQF_TX);
		st(ST_DRAINED, 1'b0);
		md(PQF_STDBY);
		st(ST_DRAINED, 1'b1);
		// Select held low across reads: drained must still track the queue
		ssn <= 1'b0;
		wr(ADDR_DATA, 32'h44);
		wr(ADDR_DATA, 32'h55);
		wb(1'b0, ADDR_DATA, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h44);
		st(ST_DRAINED, 1'b0);
		wb(1'b0, ADDR_DATA, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h55);
		st(ST_DRAINED, 1'b1);
		ssn <= 1'b1;
	endtask
	task automatic s_pins;
		wr(ADDR_PINMAP, 32'h004);
		pin(1, 1'b1);
		pin(3, 1'b1);
		wr(ADDR_DATA, 32'h33);
		pin(1, 1'b0);
		pin(3, 1'b0);
		wr(ADDR_PINMAP, 32'h008);
		pin(1, 1'b0);
		wr(ADDR_PINMAP, 32'h001);
		md(PQF_RX);
		ok <= 1'b1;
		pin(0, 1'b1);
		wr(ADDR_CTRL, 32'h4);
		wr(ADDR_PINMAP, 32'hF00);
		ms <= 1'b1;
		to <= 1'b1;
		pin(5, 1'b1);
		pin(4, 1'b1);
		pin(2, 1'b0);
		pin(3, 1'b1);
		ok <= 1'b0;
		ms <= 1'b0;
		to <= 1'b0;
	endtask
	task automatic s_link;
		logic hit;
		hit = 1'b0;
		md(PQF_STDBY);
		wr(ADDR_STATUS, 32'h8);
		wr(ADDR_DATA, 32'hA5);
		md(PQF_TX);
		u_link.send(64'h0, 64);
		for (int i = 0; i <= 56; i++)
			if (u_link.cap[i +: 8] === 8'hA5)
				hit = 1'b1;
		ck(hit, 1'b1);
		st(ST_TXDONE, 1'b1);
		wr(ADDR_CTRL, 32'h2B);
		st(ST_TXDONE, 1'b0);
		wr(ADDR_PVAL_HI, 32'h12345678);
		md(PQF_RX);
		u_link.send(64'h1E6A2C48, 32);
		st(ST_MATCH, 1'b0);
		u_link.send(64'h12345678, 32);
		st(ST_MATCH, 1'b1);
		md(PQF_STDBY);
		st(ST_MATCH, 1'b0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		s_fill();
		s_modes();
		s_pins();
		s_link();
		report_and_stop();
	end
endmodule // pqf_core_tb
`default_nettype wire
